//--- verilog/power_mode_control.sv
// Power mode control: idle and power-down sequencing with an AXI4-Lite register slave
// Functional notes
// - Idle bit set enters idle after write
// - Idle gates CPU clock, peripherals keep running
// - Idle preserves all CPU register state
// - Idle freezes port pins at entry state
// - Idle holds both bus strobes high
// - Enabled interrupt in idle clears idle bit
// - Return resumes after the idle instruction
// - Power-down bit stops oscillator, last instruction
// - RAM and registers kept through power-down
// - Only enabled external or keyboard wake power-down
// - Keyboard wake waits 1024 clocks before exit
// - Low pin restarts oscillator, release completes exit
// - First released pin exits, higher priority serviced
// - Return resumes after the power-down instruction
// - Reset exit reinitialises registers, interrupt keeps them
// - Both bits set: exit clears both, no idle
// - Cold-start flag set at power-up, software writable
// - Power-down bit cleared by any reset
// - Idle bit cleared by reset or interrupt
// - User flags owned by software only
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module power_mode_control
    import pmc_pkg::*;
#(
    parameter int KBD_WAKE_CYCLES = PMC_KBD_WAKE_CYCLES,
    parameter int WARM_RST_CYCLES = PMC_WARM_RST_CYCLES
)(
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire pmc_axi_req_t axiReq,
    output var  pmc_axi_rsp_t axiRsp,
    input  wire logic         warmRst,
    input  wire logic         irqActive,
    input  wire logic         irqVectorTaken,
    input  wire logic         ext0Pin_n,
    input  wire logic         ext1Pin_n,
    input  wire logic         kbdIrq,
    input  wire logic         aleCore,
    input  wire logic         fetchStrobeCore,
    output logic              cpuClkEn,
    output logic              periphClkEn,
    output logic              oscEnable,
    output logic              portHold,
    output logic              stateRetain,
    output logic              addrLatchStrobe,
    output logic              programFetchStrobe,
    output logic              wakeVector,
    output pmc_wake_src_t     wakeSrc,
    output logic              sfrReinit,
    output logic              coreReset
);
    // Counters are 16 and 8 bits wide
    if (KBD_WAKE_CYCLES < 1 || KBD_WAKE_CYCLES > 65535)
    begin : gKbdRangeBad
        $error("KBD_WAKE_CYCLES out of range");
    end
    if (WARM_RST_CYCLES < 1 || WARM_RST_CYCLES > 255)
    begin : gWarmRangeBad
        $error("WARM_RST_CYCLES out of range");
    end

    typedef enum logic [2:0] {
        PMC_RUN, PMC_IDLE, PMC_PDOWN, PMC_OSC_RESTART, PMC_KBD_WAIT
    } pmc_state_t;

    function automatic logic isPowerControl(input logic [11:0] addr);
        return addr == PMC_ADDR_POWER_CONTROL;
    endfunction

    function automatic logic isWakeConfig(input logic [11:0] addr);
        return addr == PMC_ADDR_WAKE_CONFIG;
    endfunction

    function automatic logic isModeStatus(input logic [11:0] addr);
        return addr == PMC_ADDR_MODE_STATUS;
    endfunction

    // Reset release through two flops
    logic rstMeta_reg;
    logic rstN;
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rstMeta_reg <= 1'b0;
            rstN        <= 1'b0;
        end
        else
        begin
            rstMeta_reg <= 1'b1;
            rstN        <= rstMeta_reg;
        end
    end

    pmc_state_t    state_reg;
    pmc_state_t    state_next;
    logic [7:0]    powerControl_reg;
    logic [7:0]    powerControl_next;
    logic [2:0]    wakeConfig_reg;
    logic [15:0]   kbdCount_reg;
    logic [7:0]    warmCount_reg;
    logic [1:0]    lowSeen_reg;
    pmc_axi_rsp_t  rsp_reg;
    logic          awHeld_reg;
    logic          wHeld_reg;
    logic [11:0]   awAddr_reg;
    logic [31:0]   wData_reg;
    logic [3:0]    wStrb_reg;

    // Write channel capture
    wire        awTake    = axiReq.awvalid && !awHeld_reg && !rsp_reg.bvalid;
    wire        wTake     = axiReq.wvalid && !wHeld_reg && !rsp_reg.bvalid;
    wire        awHave    = awHeld_reg || awTake;
    wire        wHave     = wHeld_reg || wTake;
    wire [11:0] wrAddr    = awHeld_reg ? awAddr_reg : axiReq.awaddr;
    wire [31:0] wrData    = wHeld_reg ? wData_reg : axiReq.wdata;
    wire [3:0]  wrStrb    = wHeld_reg ? wStrb_reg : axiReq.wstrb;
    wire        wrFire    = awHave && wHave && !rsp_reg.bvalid;
    wire        wrLane0   = wrStrb[0];
    wire        wrPc      = wrFire && wrLane0 && isPowerControl(wrAddr);
    wire        wrWake    = wrFire && wrLane0 && isWakeConfig(wrAddr);
    wire        wrHit     = isPowerControl(wrAddr) || isWakeConfig(wrAddr)
                            || isModeStatus(wrAddr);

    // Read channel
    wire        rdTake    = axiReq.arvalid && !rsp_reg.rvalid && !rsp_reg.arready;
    wire        rdHit     = isPowerControl(axiReq.araddr) || isWakeConfig(axiReq.araddr)
                            || isModeStatus(axiReq.araddr);
    // Reserved and serial-mode bits read as zero
    wire [31:0] rdPc      = {24'h000000, 3'h0, powerControl_reg[4:0]};
    wire [31:0] rdWake    = {29'h00000000, wakeConfig_reg};
    wire [31:0] rdStatus  = {24'h000000, 1'b0, lowSeen_reg, wakeSrc, state_reg};
    wire [31:0] rdData    = isPowerControl(axiReq.araddr) ? rdPc
                          : isWakeConfig(axiReq.araddr) ? rdWake
                          : isModeStatus(axiReq.araddr) ? rdStatus : 32'h00000000;

    // Warm reset qualification
    wire        warmFire  = warmRst && (warmCount_reg == 8'(WARM_RST_CYCLES - 1));

    // Wake decode
    wire        ext0Low   = wakeConfig_reg[PMC_BIT_EXT0_EN] && !ext0Pin_n;
    wire        ext1Low   = wakeConfig_reg[PMC_BIT_EXT1_EN] && !ext1Pin_n;
    wire        kbdWake   = wakeConfig_reg[PMC_BIT_KBD_EN] && kbdIrq;
    wire [1:0]  lowNow    = {ext1Low, ext0Low};
    wire [1:0]  lowAll    = lowSeen_reg | lowNow;
    wire        released  = (lowSeen_reg[0] && ext0Pin_n) || (lowSeen_reg[1] && ext1Pin_n);
    wire        kbdDone   = kbdCount_reg == 16'(KBD_WAKE_CYCLES - 1);
    wire        pdExit    = (state_reg == PMC_OSC_RESTART && released)
                          || (state_reg == PMC_KBD_WAIT && kbdDone);
    wire        idleExit  = state_reg == PMC_IDLE && irqActive;
    pmc_wake_src_t exitSrc;
    assign exitSrc = (state_reg == PMC_KBD_WAIT) ? PMC_SRC_KBD
                   : lowSeen_reg[0] ? PMC_SRC_EXT0 : PMC_SRC_EXT1;

    // Next power control value; software set wins over hardware clear
    always_comb
    begin
        powerControl_next = powerControl_reg;
        if (idleExit || irqVectorTaken)
            powerControl_next[PMC_BIT_IDLE] = 1'b0;
        if (pdExit)
        begin
            powerControl_next[PMC_BIT_IDLE]  = 1'b0;
            powerControl_next[PMC_BIT_PDOWN] = 1'b0;
        end
        if (wrPc)
            powerControl_next[4:0] = wrData[4:0];
    end

    // Mode sequencing
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            PMC_RUN:
            begin
                if (powerControl_reg[PMC_BIT_PDOWN])
                    state_next = PMC_PDOWN;
                else if (powerControl_reg[PMC_BIT_IDLE])
                    state_next = PMC_IDLE;
            end
            PMC_IDLE:
            begin
                if (irqActive)
                    state_next = PMC_RUN;
            end
            PMC_PDOWN:
            begin
                if (ext0Low || ext1Low)
                    state_next = PMC_OSC_RESTART;
                else if (kbdWake)
                    state_next = PMC_KBD_WAIT;
            end
            PMC_OSC_RESTART:
            begin
                if (released)
                    state_next = PMC_RUN;
            end
            PMC_KBD_WAIT:
            begin
                if (kbdDone)
                    state_next = PMC_RUN;
            end
            default:
                state_next = PMC_RUN;
        endcase
    end

    // A qualified warm reset forces run, so the outputs follow the state register
    wire        nextRun   = warmFire || state_next == PMC_RUN;
    wire        nextIdle  = !warmFire && state_next == PMC_IDLE;
    wire        nextPd    = !warmFire && state_next == PMC_PDOWN;

    // Register file and sequencer; warm reset clears all but the cold-start flag
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            state_reg        <= PMC_RUN;
            powerControl_reg <= PMC_POWER_CONTROL_RESET;
            wakeConfig_reg   <= PMC_WAKE_CONFIG_RESET;
            kbdCount_reg     <= 16'h0000;
            lowSeen_reg      <= 2'h0;
            warmCount_reg    <= 8'h00;
        end
        else if (warmFire)
        begin
            state_reg        <= PMC_RUN;
            powerControl_reg <= {3'h0, powerControl_reg[PMC_BIT_COLD], 4'h0};
            wakeConfig_reg   <= PMC_WAKE_CONFIG_RESET;
            kbdCount_reg     <= 16'h0000;
            lowSeen_reg      <= 2'h0;
            warmCount_reg    <= 8'h00;
        end
        else
        begin
            state_reg        <= state_next;
            powerControl_reg <= powerControl_next;
            if (wrWake)
                wakeConfig_reg <= wrData[2:0];
            kbdCount_reg     <= (state_reg == PMC_KBD_WAIT) ? kbdCount_reg + 16'h0001 : 16'h0000;
            lowSeen_reg      <= (state_reg == PMC_OSC_RESTART || state_next == PMC_OSC_RESTART)
                                ? lowAll : 2'h0;
            warmCount_reg    <= warmRst ? warmCount_reg + 8'h01 : 8'h00;
        end
    end

    // Mode outputs, all registered
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            cpuClkEn           <= 1'b1;
            periphClkEn        <= 1'b1;
            oscEnable          <= 1'b1;
            portHold           <= 1'b0;
            stateRetain        <= 1'b0;
            addrLatchStrobe    <= 1'b1;
            programFetchStrobe <= 1'b1;
            wakeVector         <= 1'b0;
            wakeSrc            <= PMC_SRC_NONE;
            sfrReinit          <= 1'b0;
            coreReset          <= 1'b1;
        end
        else
        begin
            cpuClkEn           <= nextRun;
            periphClkEn        <= nextRun || nextIdle;
            oscEnable          <= !nextPd;
            portHold           <= !nextRun;
            stateRetain        <= !nextRun;
            addrLatchStrobe    <= nextIdle ? 1'b1 : (nextRun ? aleCore : 1'b0);
            programFetchStrobe <= nextIdle ? 1'b1 : (nextRun ? fetchStrobeCore : 1'b0);
            wakeVector         <= (pdExit || idleExit) && !warmFire;
            if (pdExit && !warmFire)
                wakeSrc <= exitSrc;
            sfrReinit          <= warmFire;
            coreReset          <= warmFire;
        end
    end

    // AXI4-Lite slave
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            rsp_reg    <= '0;
            awHeld_reg <= 1'b0;
            wHeld_reg  <= 1'b0;
            awAddr_reg <= 12'h000;
            wData_reg  <= 32'h00000000;
            wStrb_reg  <= 4'h0;
        end
        else
        begin
            rsp_reg.awready <= awTake && !wrFire;
            rsp_reg.wready  <= wTake && !wrFire;
            if (wrFire)
            begin
                rsp_reg.awready <= !awHeld_reg;
                rsp_reg.wready  <= !wHeld_reg;
            end
            if (awTake && !wrFire)
            begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= axiReq.awaddr;
            end
            if (wTake && !wrFire)
            begin
                wHeld_reg <= 1'b1;
                wData_reg <= axiReq.wdata;
                wStrb_reg <= axiReq.wstrb;
            end
            if (wrFire)
            begin
                awHeld_reg    <= 1'b0;
                wHeld_reg     <= 1'b0;
                rsp_reg.bvalid <= 1'b1;
                rsp_reg.bresp  <= wrHit ? PMC_RESP_OKAY : PMC_RESP_SLVERR;
            end
            else if (rsp_reg.bvalid && axiReq.bready)
                rsp_reg.bvalid <= 1'b0;
            rsp_reg.arready <= rdTake;
            if (rdTake)
            begin
                rsp_reg.rvalid <= 1'b1;
                rsp_reg.rdata  <= rdData;
                rsp_reg.rresp  <= rdHit ? PMC_RESP_OKAY : PMC_RESP_SLVERR;
            end
            else if (rsp_reg.rvalid && axiReq.rready)
                rsp_reg.rvalid <= 1'b0;
        end
    end

    assign axiRsp = rsp_reg;
endmodule // power_mode_control
`default_nettype wire

//--- common/pmc_pkg.sv
// Package: register map, field positions, counts and carriers for the power mode control block
package pmc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [11:0] PMC_IDX_POWER_CONTROL = 12'h087;
    localparam logic [11:0] PMC_IDX_WAKE_CONFIG   = 12'h088;
    localparam logic [11:0] PMC_IDX_MODE_STATUS   = 12'h089;
    localparam logic [11:0] PMC_ADDR_POWER_CONTROL = 12'h21C;
    localparam logic [11:0] PMC_ADDR_WAKE_CONFIG   = 12'h220;
    localparam logic [11:0] PMC_ADDR_MODE_STATUS   = 12'h224;

    // Power control fields
    localparam int PMC_BIT_IDLE      = 0;
    localparam int PMC_BIT_PDOWN     = 1;
    localparam int PMC_BIT_USER0     = 2;
    localparam int PMC_BIT_USER1     = 3;
    localparam int PMC_BIT_COLD      = 4;
    localparam logic [7:0] PMC_POWER_CONTROL_RESET = 8'h10;

    // Wake configuration fields
    localparam int PMC_BIT_EXT0_EN = 0;
    localparam int PMC_BIT_EXT1_EN = 1;
    localparam int PMC_BIT_KBD_EN  = 2;
    localparam logic [2:0] PMC_WAKE_CONFIG_RESET = 3'h0;

    // Cycle counts
    localparam int PMC_KBD_WAKE_CYCLES  = 1024;
    localparam int PMC_WARM_RST_CYCLES  = 24;

    localparam logic [1:0] PMC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] PMC_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PMC_SRC_NONE = 2'h0,
        PMC_SRC_EXT0 = 2'h1,
        PMC_SRC_EXT1 = 2'h2,
        PMC_SRC_KBD  = 2'h3
    } pmc_wake_src_t;

    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } pmc_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } pmc_axi_rsp_t;
endpackage

//--- test/pmc_monitor.sv
// Checker: mode, wake and warm reset relations at the block ports
`timescale 1ns/1ps
`default_nettype none
module pmc_monitor
    import pmc_pkg::*;
#(
    parameter int KBD_WAKE_CYCLES = 8,
    parameter int WARM_RST_CYCLES = 4
)(
    input wire logic          core_clk,
    input wire logic          rst_b,
    input wire pmc_axi_req_t  axiReq,
    input wire pmc_axi_rsp_t  axiRsp,
    input wire logic          warmRst,
    input wire logic          irqActive,
    input wire logic          irqVectorTaken,
    input wire logic          ext0Pin_n,
    input wire logic          ext1Pin_n,
    input wire logic          kbdIrq,
    input wire logic          aleCore,
    input wire logic          fetchStrobeCore,
    input wire logic          cpuClkEn,
    input wire logic          periphClkEn,
    input wire logic          oscEnable,
    input wire logic          portHold,
    input wire logic          stateRetain,
    input wire logic          addrLatchStrobe,
    input wire logic          programFetchStrobe,
    input wire logic          wakeVector,
    input wire pmc_wake_src_t wakeSrc,
    input wire logic          sfrReinit,
    input wire logic          coreReset
);
    int warmCnt_reg;
    int waitCnt_reg;
    // Consecutive warm reset samples and cycles spent waking
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            warmCnt_reg <= 0;
            waitCnt_reg <= 0;
        end
        else
        begin
            warmCnt_reg <= warmRst ? warmCnt_reg + 1 : 0;
            waitCnt_reg <= (oscEnable && !periphClkEn) ? waitCnt_reg + 1 : 0;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_idle_strobes_high: assert property ((periphClkEn && !cpuClkEn) |->
        (addrLatchStrobe && programFetchStrobe)) else $error("strobe low in idle");
    a_held_while_stopped: assert property (!cpuClkEn |-> (portHold && stateRetain))
        else $error("state not held while stopped");
    a_pdown_all_off: assert property (!oscEnable |->
        !(cpuClkEn || periphClkEn || addrLatchStrobe || programFetchStrobe))
        else $error("activity in power-down");
    a_wake_in_run: assert property (wakeVector |-> (cpuClkEn && oscEnable && !portHold))
        else $error("wake pulse outside run");
    a_warm_length: assert property (sfrReinit |-> $past(warmCnt_reg) >= WARM_RST_CYCLES - 1)
        else $error("warm reset acted too early");
    a_kbd_wait_len: assert property ((wakeVector && wakeSrc == PMC_SRC_KBD &&
        !$past(periphClkEn)) |-> $past(waitCnt_reg) >= KBD_WAKE_CYCLES - 1)
        else $error("keyboard wake too short");
    a_pin_low_holds: assert property ((oscEnable && !periphClkEn && !ext0Pin_n &&
        !ext1Pin_n) |=> !cpuClkEn) else $error("exit while pins low");
    a_reinit_pair: assert property (sfrReinit |-> (coreReset && !wakeVector))
        else $error("reinit without core reset");
    c_ext_wake: cover property (wakeVector && wakeSrc == PMC_SRC_EXT0);
    c_warm: cover property (sfrReinit);
    c_idle_exit: cover property ((periphClkEn && !cpuClkEn) ##1 cpuClkEn);
endmodule // pmc_monitor
bind power_mode_control pmc_monitor #(
    .KBD_WAKE_CYCLES(KBD_WAKE_CYCLES),
    .WARM_RST_CYCLES(WARM_RST_CYCLES)
) u_mon (
    .core_clk(core_clk), .rst_b(rst_b), .axiReq(axiReq), .axiRsp(axiRsp),
    .warmRst(warmRst), .irqActive(irqActive), .irqVectorTaken(irqVectorTaken),
    .ext0Pin_n(ext0Pin_n), .ext1Pin_n(ext1Pin_n), .kbdIrq(kbdIrq), .aleCore(aleCore),
    .fetchStrobeCore(fetchStrobeCore), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
    .oscEnable(oscEnable), .portHold(portHold), .stateRetain(stateRetain),
    .addrLatchStrobe(addrLatchStrobe), .programFetchStrobe(programFetchStrobe),
    .wakeVector(wakeVector), .wakeSrc(wakeSrc), .sfrReinit(sfrReinit), .coreReset(coreReset)
);
`default_nettype wire

//--- test/pmc_core_model.sv
// Partner: core strobes, interrupt vectoring and wake pins
`timescale 1ns/1ps
`default_nettype none
module pmc_core_model (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic irqReq,
    input  wire logic ext0Low,
    input  wire logic ext1Low,
    input  wire logic kbdReq,
    input  wire logic wakeVector,
    output logic      aleCore,
    output logic      fetchStrobeCore,
    output logic      irqActive,
    output logic      irqVectorTaken,
    output logic      ext0Pin_n,
    output logic      ext1Pin_n,
    output logic      kbdIrq
);
    // Pins stay low only while the bench holds ext0Low or ext1Low, with or without an oscillator restart
    assign ext0Pin_n       = !ext0Low;
    assign ext1Pin_n       = !ext1Low;
    assign kbdIrq          = kbdReq;
    assign irqActive       = irqReq;
    assign fetchStrobeCore = !aleCore;
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aleCore        <= 1'b1;
            irqVectorTaken <= 1'b0;
        end
        else
        begin
            aleCore        <= !aleCore;
            irqVectorTaken <= wakeVector;
        end
    end
endmodule // pmc_core_model
`default_nettype wire

//--- test/power_mode_control_test.sv
// Testbench: registers, idle, power-down wakes and warm reset
`timescale 1ns/1ps
`default_nettype none
module power_mode_control_test;
    import pmc_pkg::*;
    localparam int          KBD = 8;
    localparam int          WARM = 4;
    localparam logic [11:0] PC = PMC_ADDR_POWER_CONTROL;
    localparam logic [11:0] WC = PMC_ADDR_WAKE_CONFIG;
    logic          core_clk, rst_b, warmRst, irqReq, ext0Low, ext1Low, kbdReq;
    logic          aleCore, fetchStrobeCore, irqActive, irqVectorTaken, ext0Pin_n, ext1Pin_n;
    logic          kbdIrq, cpuClkEn, periphClkEn, oscEnable, portHold, stateRetain;
    logic          addrLatchStrobe, programFetchStrobe, wakeVector, sfrReinit, coreReset;
    pmc_wake_src_t wakeSrc;
    pmc_axi_req_t  req;
    pmc_axi_rsp_t  rsp;
    int            badCount, nCompared, n;
    logic [31:0]   rdat;
    logic [1:0]    rres;
    wire logic [6:0] modeBits = {cpuClkEn, periphClkEn, oscEnable, portHold, stateRetain,
        addrLatchStrobe, programFetchStrobe};
    power_mode_control #(.KBD_WAKE_CYCLES(KBD), .WARM_RST_CYCLES(WARM)) dut (
        .core_clk(core_clk), .rst_b(rst_b), .axiReq(req), .axiRsp(rsp), .warmRst(warmRst),
        .irqActive(irqActive), .irqVectorTaken(irqVectorTaken), .ext0Pin_n(ext0Pin_n),
        .ext1Pin_n(ext1Pin_n), .kbdIrq(kbdIrq), .aleCore(aleCore),
        .fetchStrobeCore(fetchStrobeCore), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
        .oscEnable(oscEnable), .portHold(portHold), .stateRetain(stateRetain),
        .addrLatchStrobe(addrLatchStrobe), .programFetchStrobe(programFetchStrobe),
        .wakeVector(wakeVector), .wakeSrc(wakeSrc), .sfrReinit(sfrReinit),
        .coreReset(coreReset));
    pmc_core_model partner (
        .core_clk(core_clk), .rst_b(rst_b), .irqReq(irqReq), .ext0Low(ext0Low),
        .ext1Low(ext1Low), .kbdReq(kbdReq), .wakeVector(wakeVector), .aleCore(aleCore),
        .fetchStrobeCore(fetchStrobeCore), .irqActive(irqActive),
        .irqVectorTaken(irqVectorTaken), .ext0Pin_n(ext0Pin_n), .ext1Pin_n(ext1Pin_n),
        .kbdIrq(kbdIrq));
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = !core_clk;
    end
    task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            badCount++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("compared %0d mismatched %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic tmo(input int k);
        if (k >= 60)
        begin
            badCount++;
            summarize();
        end
    endtask
    // Bus tasks decide on negedge values, which the next rising edge samples
    task automatic bus(input pmc_axi_req_t r);
        int k;
        @(posedge core_clk);
        req <= r;
        for (k = 0; k < 60; k++)
        begin
            @(negedge core_clk);
            if (rsp.awready === 1'b1) r.awvalid = 1'b0;
            if (rsp.wready === 1'b1) r.wvalid = 1'b0;
            if (rsp.arready === 1'b1) r.arvalid = 1'b0;
            if (rsp.bvalid === 1'b1 || rsp.rvalid === 1'b1) break;
            @(posedge core_clk);
            req <= r;
        end
        tmo(k);
        rdat = rsp.rdata;
        rres = r.bready ? rsp.bresp : rsp.rresp;
        @(posedge core_clk);
        req <= '0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
        bus('{1'b1, a, 1'b1, {24'h0, d}, 4'hF, 1'b1, 1'b0, 12'h0, 1'b0});
        ck(32'(rres), 32'(e));
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] d);
        bus('{1'b0, 12'h0, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, a, 1'b1});
        ck(rdat, d);
    endtask
    task automatic waitWake(output int c);
        for (c = 0; c < 60; c++)
        begin
            @(negedge core_clk);
            if (wakeVector === 1'b1) break;
        end
        tmo(c);
    endtask
    initial
    begin
        rst_b = 1'b0;
        req = '0;
        {warmRst, irqReq, ext0Low, ext1Low, kbdReq} = '0;
        badCount = 0;
        nCompared = 0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        rc(PC, 32'h10);
        rc(WC, 32'h0);
        rc(12'h3FC, 32'h0);
        ck(32'(rres), 32'(PMC_RESP_SLVERR));
        wr(12'h3FC, 8'hFF, PMC_RESP_SLVERR);
        wr(PC, 8'h2C, PMC_RESP_OKAY);
        rc(PC, 32'h0C);
        wr(PC, 8'h0D, PMC_RESP_OKAY);
        repeat (2) @(negedge core_clk);
        ck(32'(modeBits), 32'h3F);
        @(posedge core_clk);
        irqReq <= 1'b1;
        waitWake(n);
        ck(32'(cpuClkEn), 32'h1);
        @(posedge core_clk);
        irqReq <= 1'b0;
        rc(PC, 32'h0C);
        wr(WC, 8'h03, PMC_RESP_OKAY);
        wr(PC, 8'h0F, PMC_RESP_OKAY);
        repeat (2) @(negedge core_clk);
        ck(32'(modeBits), 32'h0C);
        rc(PC, 32'h0F);
        @(posedge core_clk);
        {ext0Low, ext1Low} <= 2'h3;
        repeat (6) @(negedge core_clk);
        ck(32'(modeBits), 32'h1C);
        @(posedge core_clk);
        ext1Low <= 1'b0;
        waitWake(n);
        ck(32'(wakeSrc), 32'(PMC_SRC_EXT0));
        @(posedge core_clk);
        ext0Low <= 1'b0;
        rc(PC, 32'h0C);
        wr(WC, 8'h01, PMC_RESP_OKAY);
        wr(PC, 8'h02, PMC_RESP_OKAY);
        @(posedge core_clk);
        {ext1Low, kbdReq} <= 2'h3;
        repeat (KBD + 4) @(negedge core_clk);
        ck(32'(modeBits), 32'h0C);
        @(posedge core_clk);
        {ext1Low, kbdReq, warmRst} <= 3'h1;
        repeat (WARM - 1) @(posedge core_clk);
        warmRst <= 1'b0;
        @(negedge core_clk);
        ck(32'(modeBits), 32'h0C);
        @(posedge core_clk);
        warmRst <= 1'b1;
        repeat (WARM) @(posedge core_clk);
        warmRst <= 1'b0;
        for (n = 0; n < 10; n++)
        begin
            @(negedge core_clk);
            if (sfrReinit === 1'b1) break;
        end
        ck(32'({sfrReinit, coreReset}), 32'h3);
        rc(PC, 32'h00);
        rc(WC, 32'h0);
        wr(WC, 8'h04, PMC_RESP_OKAY);
        wr(PC, 8'h12, PMC_RESP_OKAY);
        @(posedge core_clk);
        kbdReq <= 1'b1;
        waitWake(n);
        ck(32'(n >= KBD && n <= KBD + 3), 32'h1);
        ck(32'(wakeSrc), 32'(PMC_SRC_KBD));
        @(posedge core_clk);
        kbdReq <= 1'b0;
        rc(PC, 32'h10);
        summarize();
    end
endmodule // power_mode_control_test
`default_nettype wire
